// [hdl/rssu_pkg.sv]
// Purpose: constants and carrier types of the ramp start sync unit
// Assumes: one 250 MHz clock
// Notes: config word fields follow the sync config register layout
package rssu_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam logic [7:0] SYNC_CONFIG_ADDR = 8'h02;
    localparam logic [7:0] OUT_ADD_ADDR = 8'h11;
    localparam logic [7:0] DELAY_ADDR = 8'h13;
    localparam int unsigned START_EN_LSB = 0;
    localparam int unsigned START_EN_W = 5;
    localparam int unsigned TRIG_LSB = 5;
    localparam int unsigned TRIG_W = 4;
    localparam int unsigned POL_BIT = 9;
    localparam int unsigned IMMED_BIT = 10;
    localparam int unsigned EN_TARGET = 0;
    localparam int unsigned EN_MAX_VELOCITY = 1;
    localparam int unsigned EN_RAMP = 2;
    localparam int unsigned EN_GEAR = 3;
    localparam int unsigned EN_SHADOW = 4;
    localparam int unsigned TRG_EXT = 0;
    localparam int unsigned TRG_TGT = 1;
    localparam int unsigned TRG_VEL = 2;
    localparam int unsigned TRG_CMP = 3;
    localparam logic [31:0] SYNC_CONFIG_RST = 32'h0000_0000;
    localparam logic [31:0] OUT_ADD_RST = 32'h0000_0000;
    localparam logic [31:0] DELAY_RST = 32'h0000_0000;

    // motion parameter set carried between host, pending and active copies
    typedef struct packed {
        logic [31:0] target_position;
        logic [31:0] max_velocity;
        logic [2:0] ramp_profile_select;
        logic [31:0] step_scale_factor;
    } rssu_motion_t;

    // motion events seen by the trigger logic
    typedef struct packed {
        logic compare_match_event;
        logic velocity_reached;
        logic target_reached;
    } rssu_events_t;

    typedef enum logic [2:0] {
        RSSU_IDLE = 3'b001,
        RSSU_DELAY = 3'b010,
        RSSU_FIRE = 3'b100
    } rssu_state_t;
endpackage

// [hdl/rssu_top.sv]
// Purpose: ramp start synchronisation unit: trigger select, start delay,
//   start pin and start-gated motion parameter update
// Assumes: register writes arrive as one-cycle strobes from the spi front end
// Notes: start pin is three signals; oe_n low means driven
`timescale 1ns/10ps
module rssu_top #(
    parameter int unsigned CNT_W = 32
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [2:0] mot_wr_i,
    input wire logic mot_wr_gear_i,
    input wire rssu_pkg::rssu_motion_t mot_wdata_i,
    input wire rssu_pkg::rssu_motion_t shadow_i,
    input wire rssu_pkg::rssu_events_t events_i,
    input wire logic start_pin_i,
    output logic start_pin_o,
    output logic start_pin_oe_n_o,
    output logic int_start_o,
    output rssu_pkg::rssu_motion_t active_o
);
    // the delay counter is cut from a 32-bit register, so wider makes no sense
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
        $error("CNT_W must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] cfg_q, cfg_d, out_add_q, out_add_d, delay_q, delay_d;
    logic [3:0] trig_sel;
    logic [4:0] start_en;
    logic pol, immed;
    assign trig_sel = cfg_q[rssu_pkg::TRIG_LSB +: rssu_pkg::TRIG_W];
    assign start_en = cfg_q[rssu_pkg::START_EN_LSB +: rssu_pkg::START_EN_W];
    assign pol = cfg_q[rssu_pkg::POL_BIT];
    assign immed = cfg_q[rssu_pkg::IMMED_BIT];

    always_comb begin
        cfg_d = cfg_q;
        out_add_d = out_add_q;
        delay_d = delay_q;
        if (reg_wr_i) begin
            case (reg_addr_i)
                rssu_pkg::SYNC_CONFIG_ADDR: cfg_d = reg_wdata_i;
                rssu_pkg::OUT_ADD_ADDR: out_add_d = reg_wdata_i;
                rssu_pkg::DELAY_ADDR: delay_d = reg_wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cfg_q <= rssu_pkg::SYNC_CONFIG_RST;
            out_add_q <= rssu_pkg::OUT_ADD_RST;
            delay_q <= rssu_pkg::DELAY_RST;
        end else begin
            cfg_q <= cfg_d;
            out_add_q <= out_add_d;
            delay_q <= delay_d;
        end
    end

    always_comb begin
        case (reg_addr_i)
            rssu_pkg::SYNC_CONFIG_ADDR: reg_rdata_o = cfg_q;
            rssu_pkg::OUT_ADD_ADDR: reg_rdata_o = out_add_q;
            rssu_pkg::DELAY_ADDR: reg_rdata_o = delay_q;
            default: reg_rdata_o = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger detection
    logic [3:0] lvl, lvl_q;
    logic [3:0] rise;
    logic ext_trig, int_trig, any_trig;
    // input polarity: pin normalised so that 1 means active
    assign lvl = {events_i.compare_match_event, events_i.velocity_reached,
                  events_i.target_reached, start_pin_i ~^ pol};
    // edge into active state is the trigger
    assign rise = lvl & ~lvl_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            lvl_q <= 4'h1;
        end else begin
            lvl_q <= lvl;
        end
    end

    // pin edge counts only when the pin is an input
    assign ext_trig = rise[rssu_pkg::TRG_EXT] & trig_sel[rssu_pkg::TRG_EXT];
    // each enabled internal event triggers on its own
    assign int_trig = |(rise[3:1] & trig_sel[3:1]);
    // an all-zero select leaves both terms low
    assign any_trig = ext_trig | int_trig;

    ////////////////////////////////////////////////////////////////////////
    // start delay machine
    rssu_pkg::rssu_state_t st_q, st_d;
    logic [CNT_W-1:0] dcnt_q, dcnt_d;
    logic start;

    always_comb begin
        st_d = st_q;
        dcnt_d = dcnt_q;
        start = 1'b0;
        case (st_q)
            rssu_pkg::RSSU_IDLE: begin
                if (any_trig) begin
                    // zero delay fires on the next cycle
                    if ((ext_trig && immed) || delay_q[CNT_W-1:0] == '0) begin
                        st_d = rssu_pkg::RSSU_FIRE;
                    end else begin
                        st_d = rssu_pkg::RSSU_DELAY;
                        dcnt_d = delay_q[CNT_W-1:0] - 1'b1;
                    end
                end
            end
            rssu_pkg::RSSU_DELAY: begin
                if (ext_trig && immed) begin
                    st_d = rssu_pkg::RSSU_FIRE;
                end else if (dcnt_q == '0) begin
                    st_d = rssu_pkg::RSSU_FIRE;
                end else begin
                    dcnt_d = dcnt_q - 1'b1;
                end
            end
            rssu_pkg::RSSU_FIRE: begin
                start = 1'b1;
                st_d = rssu_pkg::RSSU_IDLE;
            end
            default: st_d = rssu_pkg::RSSU_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q <= rssu_pkg::RSSU_IDLE;
            dcnt_q <= '0;
        end else begin
            st_q <= st_d;
            dcnt_q <= dcnt_d;
        end
    end

    assign int_start_o = start;

    ////////////////////////////////////////////////////////////////////////
    // start pin output
    logic [31:0] ocnt_q, ocnt_d;
    logic oact_q, oact_d;

    always_comb begin
        oact_d = oact_q;
        ocnt_d = ocnt_q;
        // active for out_add plus one cycles
        if (start) begin
            oact_d = 1'b1;
            ocnt_d = out_add_q;
        end else if (oact_q) begin
            if (ocnt_q == 32'h0000_0000) begin
                oact_d = 1'b0;
            end else begin
                ocnt_d = ocnt_q - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            oact_q <= 1'b0;
            ocnt_q <= 32'h0000_0000;
        end else begin
            oact_q <= oact_d;
            ocnt_q <= ocnt_d;
        end
    end

    // pin drives only when external trigger is off
    assign start_pin_oe_n_o = trig_sel[rssu_pkg::TRG_EXT];
    // active low unless polarity bit set
    assign start_pin_o = oact_q ~^ pol;

    ////////////////////////////////////////////////////////////////////////
    // motion parameter gating
    rssu_pkg::rssu_motion_t act_q, act_d, pend_q, pend_d;
    logic [3:0] pend_v_q, pend_v_d;
    logic [3:0] wr;
    assign wr = {mot_wr_gear_i, mot_wr_i};

    always_comb begin
        act_d = act_q;
        pend_d = pend_q;
        pend_v_d = pend_v_q;
        // shadow set first, direct or pending values then override
        if (start && start_en[rssu_pkg::EN_SHADOW]) begin
            act_d = shadow_i;
        end
        // every held field applies on the same start
        if (start) begin
            if (pend_v_q[rssu_pkg::EN_TARGET]) begin
                act_d.target_position = pend_q.target_position;
            end
            if (pend_v_q[rssu_pkg::EN_MAX_VELOCITY]) begin
                act_d.max_velocity = pend_q.max_velocity;
            end
            if (pend_v_q[rssu_pkg::EN_RAMP]) begin
                act_d.ramp_profile_select = pend_q.ramp_profile_select;
            end
            if (pend_v_q[rssu_pkg::EN_GEAR]) begin
                act_d.step_scale_factor = pend_q.step_scale_factor;
            end
            pend_v_d = 4'h0;
        end
        // clear enable bit writes through at once
        // set enable bit holds the write
        if (wr[rssu_pkg::EN_TARGET]) begin
            if (start_en[rssu_pkg::EN_TARGET]) begin
                pend_d.target_position = mot_wdata_i.target_position;
                pend_v_d[rssu_pkg::EN_TARGET] = 1'b1;
            end else begin
                act_d.target_position = mot_wdata_i.target_position;
            end
        end
        if (wr[rssu_pkg::EN_MAX_VELOCITY]) begin
            if (start_en[rssu_pkg::EN_MAX_VELOCITY]) begin
                pend_d.max_velocity = mot_wdata_i.max_velocity;
                pend_v_d[rssu_pkg::EN_MAX_VELOCITY] = 1'b1;
            end else begin
                act_d.max_velocity = mot_wdata_i.max_velocity;
            end
        end
        if (wr[rssu_pkg::EN_RAMP]) begin
            if (start_en[rssu_pkg::EN_RAMP]) begin
                pend_d.ramp_profile_select = mot_wdata_i.ramp_profile_select;
                pend_v_d[rssu_pkg::EN_RAMP] = 1'b1;
            end else begin
                act_d.ramp_profile_select = mot_wdata_i.ramp_profile_select;
            end
        end
        if (wr[rssu_pkg::EN_GEAR]) begin
            if (start_en[rssu_pkg::EN_GEAR]) begin
                pend_d.step_scale_factor = mot_wdata_i.step_scale_factor;
                pend_v_d[rssu_pkg::EN_GEAR] = 1'b1;
            end else begin
                act_d.step_scale_factor = mot_wdata_i.step_scale_factor;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            act_q <= '0;
            pend_q <= '0;
            pend_v_q <= 4'h0;
        end else begin
            act_q <= act_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
        end
    end

    assign active_o = act_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // a trigger in the fire cycle is dropped, so it is left out here
    sequence s_trig_immed;
        ext_trig && immed && st_q != rssu_pkg::RSSU_FIRE;
    endsequence

    a_none_selected: assert property (@(posedge clk_i) disable iff (!nrst_i)
        trig_sel == 4'h0 |-> !any_trig)
        else $error("trigger taken with empty select");
    a_pin_dir: assert property (@(posedge clk_i) disable iff (!nrst_i)
        start_pin_oe_n_o == trig_sel[0])
        else $error("start pin direction wrong");
    a_ext_edge: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (trig_sel[0] && st_q == rssu_pkg::RSSU_IDLE && rise[0]) |=> 
        st_q != rssu_pkg::RSSU_IDLE)
        else $error("pin edge not taken");
    a_tgt_trig: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (trig_sel[1] && rise[1] && st_q == rssu_pkg::RSSU_IDLE) |=>
        st_q != rssu_pkg::RSSU_IDLE)
        else $error("target reached trigger lost");
    a_immed_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_trig_immed |=> int_start_o)
        else $error("immediate start late");
    a_zero_delay: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (any_trig && st_q == rssu_pkg::RSSU_IDLE && delay_q[CNT_W-1:0] == '0)
        |=> int_start_o)
        else $error("zero delay start late");
    a_one_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
        int_start_o |=> !int_start_o)
        else $error("start repeated");
    a_out_level: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (int_start_o && !pol) |=> !start_pin_o)
        else $error("start output level wrong");
    a_out_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (int_start_o && out_add_q == 32'h0) |=> oact_q ##1 !oact_q)
        else $error("start output length wrong");
    a_direct_wr: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mot_wr_i[0] && !start_en[0]) |=>
        active_o.target_position == $past(mot_wdata_i.target_position))
        else $error("direct write not applied");
endmodule

// [testbench/rssu_peer_model.sv]
// Purpose: peer controller sharing the start pin with the unit
// Assumes: the peer lets go of the pin whenever the unit drives it
// Notes: the peer idles at the inactive level, so no false edges
`timescale 1ns/10ps
module rssu_peer_model (
    input wire logic pol_i,
    input wire logic fire_i,
    input wire logic dev_pin_i,
    input wire logic dev_oe_n_i,
    output logic pin_o
);
    logic peer_lvl;
    assign peer_lvl = fire_i ? pol_i : ~pol_i;
    // wire level: the unit wins while its enable is low
    assign pin_o = dev_oe_n_i ? peer_lvl : dev_pin_i;
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench of the ramp start sync unit
// Assumes: 250 MHz clock, synchronous active-low reset
// Notes: row loop covers trigger sources; hand tests cover the rest
`timescale 1ns/10ps
module tb_top;
    typedef struct {
        logic [31:0] cfg;
        int src;
        logic [31:0] dly;
        int lat;
    } rssu_row_t;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o;
    logic [2:0] mot_wr_i = 3'h0;
    logic mot_wr_gear_i = 1'b0;
    rssu_pkg::rssu_motion_t mot_wdata_i = '0;
    rssu_pkg::rssu_motion_t shadow_i = '0;
    rssu_pkg::rssu_events_t events_i = '0;
    logic start_pin_i;
    logic start_pin_o;
    logic start_pin_oe_n_o;
    logic int_start_o;
    rssu_pkg::rssu_motion_t active_o;
    logic pol = 1'b0;
    logic ext_fire = 1'b0;
    int fail_count = 0;
    int check_count = 0;
    int n;
    int starts;
    int pinact;
    rssu_row_t rows[9];
    ////////////////////////////////////////
    rssu_top u_dut (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .mot_wr_i(mot_wr_i),
        .mot_wr_gear_i(mot_wr_gear_i),
        .mot_wdata_i(mot_wdata_i),
        .shadow_i(shadow_i),
        .events_i(events_i),
        .start_pin_i(start_pin_i),
        .start_pin_o(start_pin_o),
        .start_pin_oe_n_o(start_pin_oe_n_o),
        .int_start_o(int_start_o),
        .active_o(active_o)
    );
    rssu_peer_model u_peer (
        .pol_i(pol),
        .fire_i(ext_fire),
        .dev_pin_i(start_pin_o),
        .dev_oe_n_i(start_pin_oe_n_o),
        .pin_o(start_pin_i)
    );
    always #2 clk_i = ~clk_i;
    ////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tick();
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick();
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        tick();
        reg_addr_i = a;
        #1;
        chk(reg_rdata_o, e);
    endtask
    task automatic mw(input logic [2:0] w, input logic g,
                      input rssu_pkg::rssu_motion_t d);
        tick();
        mot_wdata_i = d;
        mot_wr_i = w;
        mot_wr_gear_i = g;
        tick();
        mot_wr_i = 3'h0;
        mot_wr_gear_i = 1'b0;
    endtask
    // source 4 raises all three motion events together
    task automatic src_set(input int s, input logic v);
        case (s)
            0: ext_fire = v;
            1: events_i.target_reached = v;
            2: events_i.velocity_reached = v;
            3: events_i.compare_match_event = v;
            default: events_i = {3{v}};
        endcase
    endtask
    task automatic observe(input int s);
        n = 0;
        starts = 0;
        pinact = 0;
        src_set(s, 1'b1);
        for (int i = 1; i <= 14; i++) begin
            tick();
            if (int_start_o === 1'b1 && n == 0) n = i;
            if (int_start_o === 1'b1) starts++;
            if (start_pin_oe_n_o === 1'b0 && start_pin_o === pol) pinact++;
        end
        src_set(4, 1'b0);
        ext_fire = 1'b0;
        tick();
        tick();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    // watchdog: roughly sixteen times the expected run length
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        wrap_up();
    end
    initial begin
        rows[0] = '{32'h000, 1, 32'h0, 0};
        rows[1] = '{32'h040, 1, 32'h0, 1};
        rows[2] = '{32'h040, 2, 32'h0, 0};
        rows[3] = '{32'h080, 2, 32'h2, 3};
        rows[4] = '{32'h100, 3, 32'h5, 6};
        rows[5] = '{32'h1e0, 2, 32'h1, 2};
        rows[6] = '{32'h020, 0, 32'h3, 4};
        rows[7] = '{32'h240, 1, 32'h0, 1};
        rows[8] = '{32'h220, 0, 32'h1, 2};
        repeat (5) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        wr(rssu_pkg::OUT_ADD_ADDR, 32'h0000_0002);
        foreach (rows[k]) begin
            wr(rssu_pkg::SYNC_CONFIG_ADDR, rows[k].cfg);
            wr(rssu_pkg::DELAY_ADDR, rows[k].dly);
            pol = rows[k].cfg[9];
            tick();
            tick();
            observe(rows[k].src);
            chk(n, rows[k].lat);
            chk(starts, rows[k].lat != 0);
            chk(start_pin_oe_n_o, rows[k].cfg[5]);
            if (rows[k].cfg[5] == 1'b0 && rows[k].lat != 0)
                chk(pinact, 3);
            $display("row %0d done", k);
        end
        pol = 1'b0;
        wr(rssu_pkg::SYNC_CONFIG_ADDR, 32'h040);
        mw(3'h7, 1'b1, '{32'h11, 32'h22, 3'h5, 32'h33});
        chk(active_o, {32'h11, 32'h22, 3'h5, 32'h33});
        $display("direct write test done");
        shadow_i = '{32'h0a, 32'h0b, 3'h2, 32'h0c};
        wr(rssu_pkg::SYNC_CONFIG_ADDR, 32'h057);
        wr(rssu_pkg::DELAY_ADDR, 32'h0);
        mw(3'h7, 1'b1, '{32'h100, 32'h200, 3'h3, 32'h44});
        chk(active_o, {32'h11, 32'h22, 3'h5, 32'h44});
        observe(1);
        chk(active_o, {32'h100, 32'h200, 3'h3, 32'h0c});
        wr(rssu_pkg::SYNC_CONFIG_ADDR, 32'h048);
        mw(3'h1, 1'b1, '{32'h500, 32'h600, 3'h1, 32'h77});
        chk(active_o, {32'h500, 32'h200, 3'h3, 32'h0c});
        observe(1);
        chk(active_o, {32'h500, 32'h200, 3'h3, 32'h77});
        $display("held write test done");
        wr(rssu_pkg::SYNC_CONFIG_ADDR, 32'h460);
        wr(rssu_pkg::DELAY_ADDR, 32'h6);
        tick();
        src_set(1, 1'b1);
        tick();
        tick();
        observe(0);
        chk(n, 1);
        chk(starts, 1);
        wr(rssu_pkg::SYNC_CONFIG_ADDR, 32'h1c0);
        wr(rssu_pkg::DELAY_ADDR, 32'h1);
        wr(rssu_pkg::OUT_ADD_ADDR, 32'h0);
        observe(4);
        chk(n, 2);
        chk(starts, 1);
        chk(pinact, 1);
        $display("priority and merge test done");
        rd(rssu_pkg::OUT_ADD_ADDR, 32'h0);
        rd(rssu_pkg::SYNC_CONFIG_ADDR, 32'h1c0);
        wr(8'h55, 32'hffff_ffff);
        rd(8'h55, 32'h0);
        tick();
        nrst_i = 1'b0;
        repeat (5) tick();
        nrst_i = 1'b1;
        rd(rssu_pkg::SYNC_CONFIG_ADDR, rssu_pkg::SYNC_CONFIG_RST);
        rd(rssu_pkg::OUT_ADD_ADDR, rssu_pkg::OUT_ADD_RST);
        rd(rssu_pkg::DELAY_ADDR, rssu_pkg::DELAY_RST);
        chk(int_start_o, 1'b0);
        chk(start_pin_o, 1'b1);
        chk(active_o, '0);
        $display("register and reset test done");
        wrap_up();
    end
endmodule
